/* design/phy_nway_pkg.sv */
package phy_nway_pkg;
  // register indices as seen on the management interface
  localparam logic [4:0] REG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_CONTROL_ONE = 5'h10;
  localparam logic [4:0] REG_CROSSOVER = 5'h17;

  // expansion register fields
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_PARTNER_NP = 3;
  localparam int EXP_LOCAL_NP = 2;
  localparam int EXP_PAGE_RX = 1;
  localparam int EXP_PARTNER_AN = 0;
  localparam logic [15:0] EXP_RESET = 16'h0000;

  // control register one fields
  localparam int CTL_BICOLOUR = 15;
  localparam int CTL_SLEW = 14;
  localparam int CTL_RF_CONSIDER = 13;
  localparam int CTL_FORCED_LED = 12;
  localparam int CTL_MLT3 = 11;
  localparam int CTL_CLK_INV = 10;
  localparam int CTL_CLK_DLY = 9;
  localparam int CTL_MAC_SEL = 8;
  localparam int CTL_APS = 7;
  localparam int CTL_NWAY_PS_OFF = 6;
  localparam int CTL_XOVER_ALL = 5;
  localparam int CTL_FEF_OFF = 4;
  localparam int CTL_REPEAT = 3;
  localparam int CTL_JABBER = 2;
  localparam int CTL_HEARTBEAT = 1;
  localparam int CTL_DSP_WD_SKIP = 0;
  localparam logic [15:0] CTL_RESET = 16'h118c;
  // defaults of bits that no strap touches, applied at strap load
  localparam logic [15:0] CTL_FIXED = 16'h00a4;

  // crossover register
  localparam logic [7:0] XOVER_EN_RESET = 8'hff;
  localparam logic [7:0] MDIX_SEL_RESET = 8'h00;

  localparam logic [1:0] LED_DIRECT = 2'b11;

  // strap vector layout
  localparam int STRAP_W = 14;
  localparam int STP_SLEW = 0;
  localparam int STP_FORCED_LED = 1;
  localparam int STP_MLT3 = 2;
  localparam int STP_CLK_INV = 3;
  localparam int STP_CLK_DLY = 4;
  localparam int STP_MAC_SEL = 5;
  localparam int STP_REPEAT = 6;
  localparam int STP_LED_LO = 7;
  localparam int STP_ADDR_LO = 9;
  localparam logic [2:0] STRAP_LOAD_CYCLES = 3'h4;

  // management frame
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hd;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] FRAME_START = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
endpackage : phy_nway_pkg

/* design/mgmt_frame_slave.sv */
`timescale 1ns/1ps
module mgmt_frame_slave (
  input wire logic i_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_mdc, // management clock pin
  input wire logic i_mdio, // management data pin, input side
  input wire logic [4:0] i_phy_addr, // our station address
  input wire logic [15:0] i_rd_data, // read data for o_addr
  output logic o_mdio, // management data pin, output side
  output logic o_mdio_oe, // high while we drive the data pin
  output logic [4:0] o_addr, // register index of current frame
  output logic o_rd_strobe, // one cycle: read data taken
  output logic o_wr_strobe, // one cycle: write data valid
  output logic [15:0] o_wr_data // write data
);
  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_TURN, ST_RDATA, ST_WTURN,
    ST_WDATA} frame_e;

  frame_e state_ff;
  logic mdc_s1_ff, mdc_s2_ff, mdc_s3_ff, mdc_q_ff;
  logic dio_s1_ff, dio_s2_ff, dio_s3_ff;
  logic [5:0] ones_ff;
  logic [3:0] cnt_ff;
  logic [12:0] hdr_ff;
  logic [15:0] sh_ff;
  logic rise;
  logic bit_in;
  logic [13:0] hdr_full;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mdc_s1_ff <= 1'b0;
      mdc_s2_ff <= 1'b0;
      mdc_s3_ff <= 1'b0;
      dio_s1_ff <= 1'b1;
      dio_s2_ff <= 1'b1;
      dio_s3_ff <= 1'b1;
      mdc_q_ff <= 1'b0;
    end
    else
    begin
      mdc_s1_ff <= i_mdc;
      mdc_s2_ff <= mdc_s1_ff;
      mdc_s3_ff <= mdc_s2_ff;
      dio_s1_ff <= i_mdio;
      dio_s2_ff <= dio_s1_ff;
      dio_s3_ff <= dio_s2_ff;
      if (mdc_s2_ff == mdc_s3_ff)
        mdc_q_ff <= mdc_s3_ff;
    end
  end

  assign rise = (mdc_s2_ff == mdc_s3_ff) && mdc_s3_ff && !mdc_q_ff;
  assign bit_in = dio_s3_ff;
  assign hdr_full = {hdr_ff, bit_in};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_ff <= ST_IDLE;
      ones_ff <= 6'h00;
      cnt_ff <= 4'h0;
      hdr_ff <= 13'h0000;
      sh_ff <= 16'h0000;
      o_addr <= 5'h00;
      o_mdio <= 1'b1;
      o_mdio_oe <= 1'b0;
      o_rd_strobe <= 1'b0;
      o_wr_strobe <= 1'b0;
      o_wr_data <= 16'h0000;
    end
    else
    begin
      o_rd_strobe <= 1'b0;
      o_wr_strobe <= 1'b0;
      if (rise)
      begin
        case (state_ff)
          ST_IDLE:
          begin
            cnt_ff <= 4'h0;
            if (bit_in)
            begin
              if (ones_ff != phy_nway_pkg::PREAMBLE_ONES)
                ones_ff <= ones_ff + 6'h01;
            end
            else
            begin
              ones_ff <= 6'h00;
              if (ones_ff == phy_nway_pkg::PREAMBLE_ONES)
              begin
                hdr_ff <= 13'h0000;
                cnt_ff <= 4'h1;
                state_ff <= ST_HDR;
              end
            end
          end
          ST_HDR:
          begin
            hdr_ff <= hdr_full[12:0];
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == phy_nway_pkg::HDR_LAST)
            begin
              cnt_ff <= 4'h0;
              o_addr <= hdr_full[4:0];
              state_ff <= ST_IDLE;
              if (hdr_full[13:12] == phy_nway_pkg::FRAME_START &&
                  hdr_full[9:5] == i_phy_addr)
              begin
                if (hdr_full[11:10] == phy_nway_pkg::OP_READ)
                  state_ff <= ST_TURN;
                else if (hdr_full[11:10] == phy_nway_pkg::OP_WRITE)
                  state_ff <= ST_WTURN;
              end
            end
          end
          ST_TURN:
          begin
            // second turnaround bit is ours: drive zero, take the data
            o_mdio <= 1'b0;
            o_mdio_oe <= 1'b1;
            sh_ff <= i_rd_data;
            o_rd_strobe <= 1'b1;
            state_ff <= ST_RDATA;
          end
          ST_RDATA:
          begin
            o_mdio <= sh_ff[15];
            sh_ff <= {sh_ff[14:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == phy_nway_pkg::DATA_LAST)
              state_ff <= ST_IDLE;
          end
          ST_WTURN:
          begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'h1)
            begin
              cnt_ff <= 4'h0;
              state_ff <= ST_WDATA;
            end
          end
          ST_WDATA:
          begin
            sh_ff <= {sh_ff[14:0], bit_in};
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == phy_nway_pkg::DATA_LAST)
            begin
              o_wr_data <= {sh_ff[14:0], bit_in};
              o_wr_strobe <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
          default:
            state_ff <= ST_IDLE;
        endcase
        // release the pin one bit after the last data bit went out
        if (state_ff == ST_IDLE || state_ff == ST_HDR)
        begin
          o_mdio_oe <= 1'b0;
          o_mdio <= 1'b1;
        end
      end
    end
  end
endmodule : mgmt_frame_slave

/* design/phy_nway_expansion_and_control.sv */
`timescale 1ns/1ps
module phy_nway_expansion_and_control (
  input wire logic i_clk, // 100 MHz system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_mdc, // management clock pin
  input wire logic i_mdio, // management data pin, input side
  output logic o_mdio, // management data pin, output side
  output logic o_mdio_oe, // high while driving management data
  input wire logic [4:0] i_phy_addr_strap, // station address pins
  input wire logic [1:0] i_led_style_field, // led style pins
  input wire logic [6:0] i_strap, // strap pins, see package layout
  input wire logic i_pd_fault, // parallel detection fault event
  input wire logic i_page_received, // new page arrived event
  input wire logic i_an_enable, // negotiation enabled
  input wire logic i_partner_an_able, // partner can negotiate
  output logic o_bicolour_led_select, // bicolour direct LED drive
  output logic o_fast_slew, // faster output slew
  output logic o_remote_fault_consider, // rf in consistency match
  output logic o_forced_link_led_suppress, // hide forced mode LEDs
  output logic o_ternary_line_speed_detect, // follow 10 to 100 change
  output logic o_receive_clock_invert, // invert receive clock
  output logic o_receive_clock_delay, // delay receive clock
  output logic o_mac_interface_select, // serial mac interface mode
  output logic o_auto_power_save_enable, // automatic power save
  output logic o_negotiation_power_save_off, // no save in negotiation
  output logic [7:0] o_port_crossover_enable, // effective per port
  output logic [7:0] o_mdix_select, // forced channel per port
  output logic o_far_end_fault_off, // fibre far end fault off
  output logic o_repeater_mode, // repeater mode
  output logic o_long_transmit_guard_enable, // jabber check at 10M
  output logic o_collision_test_check_enable, // heartbeat at 10M
  output logic o_dsp_watchdog_skip // dsp watchdog bypass
);
  localparam int SW = phy_nway_pkg::STRAP_W;

  logic [SW-1:0] strap_raw;
  logic [SW-1:0] st_s1_ff, st_s2_ff, st_s3_ff, st_q_ff;
  logic [2:0] load_cnt_ff;
  logic load_pulse_ff;
  logic direct_led;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl_strap;
  logic [15:0] nxt_ctrl_wr;
  logic [7:0] xover_en_ff;
  logic [7:0] mdix_sel_ff;
  logic pd_fault_lh_ff;
  logic page_rx_lh_ff;
  logic [15:0] exp_value;
  logic [15:0] rd_data;
  logic [4:0] addr;
  logic rd_strobe;
  logic wr_strobe;
  logic [15:0] wr_data;
  logic exp_read;

  assign strap_raw = {i_phy_addr_strap, i_led_style_field, i_strap};

  // pins pass three stages; the filtered copy moves only when 2 and 3 agree
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_s1_ff <= '0;
      st_s2_ff <= '0;
      st_s3_ff <= '0;
      st_q_ff <= '0;
    end
    else
    begin
      st_s1_ff <= strap_raw;
      st_s2_ff <= st_s1_ff;
      st_s3_ff <= st_s2_ff;
      for (int i = 0; i < SW; i++)
        if (st_s2_ff[i] == st_s3_ff[i])
          st_q_ff[i] <= st_s3_ff[i];
    end
  end

  // straps are taken once the synchroniser has filled after release
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      load_cnt_ff <= 3'h0;
    else if (load_cnt_ff != phy_nway_pkg::STRAP_LOAD_CYCLES)
      load_cnt_ff <= load_cnt_ff + 3'h1;
  end

  // the filtered copy settles on the same edge the count ends, so the load
  // waits one edge more; any sooner would take the reset zeros instead
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      load_pulse_ff <= 1'b0;
    else
      load_pulse_ff <=
        (load_cnt_ff == phy_nway_pkg::STRAP_LOAD_CYCLES - 3'h1);
  end

  assign direct_led = st_q_ff[phy_nway_pkg::STP_LED_LO +: 2] ==
    phy_nway_pkg::LED_DIRECT;

  always_comb
  begin
    nxt_ctrl_strap = phy_nway_pkg::CTL_FIXED;
    nxt_ctrl_strap[phy_nway_pkg::CTL_SLEW] =
      st_q_ff[phy_nway_pkg::STP_SLEW];
    nxt_ctrl_strap[phy_nway_pkg::CTL_CLK_INV] =
      st_q_ff[phy_nway_pkg::STP_CLK_INV];
    nxt_ctrl_strap[phy_nway_pkg::CTL_CLK_DLY] =
      st_q_ff[phy_nway_pkg::STP_CLK_DLY];
    if (direct_led)
    begin
      // strap pins double as LEDs here, so the table defaults hold
      nxt_ctrl_strap[phy_nway_pkg::CTL_FORCED_LED] = 1'b1;
      nxt_ctrl_strap[phy_nway_pkg::CTL_MLT3] = 1'b1;
      nxt_ctrl_strap[phy_nway_pkg::CTL_MAC_SEL] = 1'b1;
      nxt_ctrl_strap[phy_nway_pkg::CTL_REPEAT] = 1'b1;
    end
    else
    begin
      nxt_ctrl_strap[phy_nway_pkg::CTL_FORCED_LED] =
        !st_q_ff[phy_nway_pkg::STP_FORCED_LED];
      nxt_ctrl_strap[phy_nway_pkg::CTL_MLT3] =
        !st_q_ff[phy_nway_pkg::STP_MLT3];
      nxt_ctrl_strap[phy_nway_pkg::CTL_MAC_SEL] =
        st_q_ff[phy_nway_pkg::STP_MAC_SEL];
      nxt_ctrl_strap[phy_nway_pkg::CTL_REPEAT] =
        st_q_ff[phy_nway_pkg::STP_REPEAT];
    end
    // a zero here is reserved and would leave the mac side dead
    nxt_ctrl_strap[phy_nway_pkg::CTL_MAC_SEL] = 1'b1;
  end

  always_comb
  begin
    nxt_ctrl_wr = wr_data;
    nxt_ctrl_wr[phy_nway_pkg::CTL_MAC_SEL] = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ctrl_ff <= phy_nway_pkg::CTL_RESET;
    else if (load_pulse_ff)
      ctrl_ff <= nxt_ctrl_strap;
    else if (wr_strobe && addr == phy_nway_pkg::REG_CONTROL_ONE)
      ctrl_ff <= nxt_ctrl_wr;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      xover_en_ff <= phy_nway_pkg::XOVER_EN_RESET;
      mdix_sel_ff <= phy_nway_pkg::MDIX_SEL_RESET;
    end
    else if (wr_strobe && addr == phy_nway_pkg::REG_CROSSOVER)
    begin
      xover_en_ff <= wr_data[15:8];
      mdix_sel_ff <= wr_data[7:0];
    end
  end

  assign exp_read = rd_strobe && addr == phy_nway_pkg::REG_EXPANSION;

  // a new event in the read cycle survives the clear
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pd_fault_lh_ff <= 1'b0;
      page_rx_lh_ff <= 1'b0;
    end
    else
    begin
      if (i_pd_fault)
        pd_fault_lh_ff <= 1'b1;
      else if (exp_read)
        pd_fault_lh_ff <= 1'b0;
      if (i_page_received)
        page_rx_lh_ff <= 1'b1;
      else if (exp_read)
        page_rx_lh_ff <= 1'b0;
    end
  end

  always_comb
  begin
    exp_value = phy_nway_pkg::EXP_RESET;
    exp_value[phy_nway_pkg::EXP_PD_FAULT] =
      pd_fault_lh_ff | i_pd_fault;
    exp_value[phy_nway_pkg::EXP_PAGE_RX] =
      page_rx_lh_ff | i_page_received;
    exp_value[phy_nway_pkg::EXP_PARTNER_NP] = 1'b0;
    exp_value[phy_nway_pkg::EXP_LOCAL_NP] = 1'b0;
    exp_value[phy_nway_pkg::EXP_PARTNER_AN] =
      i_an_enable & i_partner_an_able;
  end

  always_comb
  begin
    case (addr)
      phy_nway_pkg::REG_EXPANSION: rd_data = exp_value;
      phy_nway_pkg::REG_CONTROL_ONE: rd_data = ctrl_ff;
      phy_nway_pkg::REG_CROSSOVER: rd_data = {xover_en_ff, mdix_sel_ff};
      default: rd_data = 16'h0000;
    endcase
  end

  mgmt_frame_slave u_mgmt (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_mdc(i_mdc),
    .i_mdio(i_mdio),
    .i_phy_addr(st_q_ff[phy_nway_pkg::STP_ADDR_LO +: 5]),
    .i_rd_data(rd_data),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe),
    .o_addr(addr),
    .o_rd_strobe(rd_strobe),
    .o_wr_strobe(wr_strobe),
    .o_wr_data(wr_data)
  );

  // outputs are registered once more so that derived ones match in time
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_bicolour_led_select <= 1'b0;
      o_fast_slew <= 1'b0;
      o_remote_fault_consider <= 1'b0;
      o_forced_link_led_suppress <= 1'b0;
      o_ternary_line_speed_detect <= 1'b0;
      o_receive_clock_invert <= 1'b0;
      o_receive_clock_delay <= 1'b0;
      o_mac_interface_select <= 1'b0;
      o_auto_power_save_enable <= 1'b0;
      o_negotiation_power_save_off <= 1'b0;
      o_port_crossover_enable <= 8'h00;
      o_mdix_select <= 8'h00;
      o_far_end_fault_off <= 1'b0;
      o_repeater_mode <= 1'b0;
      o_long_transmit_guard_enable <= 1'b0;
      o_collision_test_check_enable <= 1'b0;
      o_dsp_watchdog_skip <= 1'b0;
    end
    else
    begin
      o_bicolour_led_select <= ctrl_ff[phy_nway_pkg::CTL_BICOLOUR] &
        direct_led;
      o_fast_slew <= ctrl_ff[phy_nway_pkg::CTL_SLEW];
      o_remote_fault_consider <=
        ctrl_ff[phy_nway_pkg::CTL_RF_CONSIDER];
      o_forced_link_led_suppress <=
        ctrl_ff[phy_nway_pkg::CTL_FORCED_LED];
      o_ternary_line_speed_detect <= ctrl_ff[phy_nway_pkg::CTL_MLT3];
      o_receive_clock_invert <= ctrl_ff[phy_nway_pkg::CTL_CLK_INV];
      o_receive_clock_delay <= ctrl_ff[phy_nway_pkg::CTL_CLK_DLY];
      o_mac_interface_select <= ctrl_ff[phy_nway_pkg::CTL_MAC_SEL];
      o_auto_power_save_enable <= ctrl_ff[phy_nway_pkg::CTL_APS];
      o_negotiation_power_save_off <=
        ctrl_ff[phy_nway_pkg::CTL_NWAY_PS_OFF];
      o_port_crossover_enable <= xover_en_ff &
        {8{ctrl_ff[phy_nway_pkg::CTL_XOVER_ALL]}};
      o_mdix_select <= mdix_sel_ff;
      o_far_end_fault_off <= ctrl_ff[phy_nway_pkg::CTL_FEF_OFF];
      o_repeater_mode <= ctrl_ff[phy_nway_pkg::CTL_REPEAT];
      o_long_transmit_guard_enable <=
        ctrl_ff[phy_nway_pkg::CTL_JABBER];
      o_collision_test_check_enable <=
        ctrl_ff[phy_nway_pkg::CTL_HEARTBEAT];
      o_dsp_watchdog_skip <= ctrl_ff[phy_nway_pkg::CTL_DSP_WD_SKIP];
    end
  end
endmodule : phy_nway_expansion_and_control

/* tb/phy_nway_expansion_and_control_props.sv */
`timescale 1ns/1ps
module phy_nway_expansion_and_control_props (
  input wire logic i_clk, // clock
  input wire logic i_rstn, // reset
  input wire logic [1:0] i_led_style_field, // led pins
  input wire logic [6:0] i_strap, // straps
  input wire logic o_mdio_oe, // data pin enable
  input wire logic o_bicolour_led_select, // bicolour
  input wire logic o_fast_slew, // slew
  input wire logic o_remote_fault_consider, // rf match
  input wire logic o_forced_link_led_suppress, // forced led
  input wire logic o_ternary_line_speed_detect, // speed detect
  input wire logic o_receive_clock_invert, // clock invert
  input wire logic o_receive_clock_delay, // clock delay
  input wire logic o_mac_interface_select, // mac mode
  input wire logic o_auto_power_save_enable, // aps
  input wire logic o_negotiation_power_save_off, // nway save
  input wire logic [7:0] o_port_crossover_enable, // crossover
  input wire logic o_far_end_fault_off, // fef
  input wire logic o_repeater_mode, // repeat
  input wire logic o_long_transmit_guard_enable, // jabber
  input wire logic o_collision_test_check_enable, // heartbeat
  input wire logic o_dsp_watchdog_skip // watchdog
);
  default clocking dflt @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  logic dir;
  assign dir = (i_led_style_field == phy_nway_pkg::LED_DIRECT);
  // strap load lands a few edges after release, well before edge 7
  chk_mac_stays_high:
  assert property (!$fell(o_mac_interface_select))
    else $error("mac select dropped");
  chk_bicolour_gated:
  assert property (o_bicolour_led_select |-> dir)
    else $error("bicolour outside direct mode");
  chk_strap_inverted:
  assert property ($rose(i_rstn) |-> ##7
    o_forced_link_led_suppress == (dir | !i_strap[1]) &&
    o_ternary_line_speed_detect == (dir | !i_strap[2]))
    else $error("inverted strap default wrong");
  chk_strap_plain:
  assert property ($rose(i_rstn) |-> ##7
    {o_fast_slew, o_receive_clock_invert, o_receive_clock_delay} ==
    {i_strap[0], i_strap[3], i_strap[4]})
    else $error("plain strap default wrong");
  chk_strap_repeat:
  assert property ($rose(i_rstn) |-> ##7 o_repeater_mode == (dir | i_strap[6]))
    else $error("repeat default wrong");
  chk_power_defaults:
  assert property ($rose(i_rstn) |-> ##7
    o_auto_power_save_enable && !o_negotiation_power_save_off)
    else $error("power save default wrong");
  chk_tenbase_defaults:
  assert property ($rose(i_rstn) |-> ##7 o_long_transmit_guard_enable &&
    !o_collision_test_check_enable && !o_dsp_watchdog_skip)
    else $error("10M default wrong");
  chk_fault_defaults:
  assert property ($rose(i_rstn) |-> ##7
    !o_remote_fault_consider && !o_far_end_fault_off)
    else $error("fault default wrong");
  chk_xover_defaults:
  assert property ($rose(i_rstn) |-> ##7 o_port_crossover_enable == 8'hff)
    else $error("crossover default wrong");
  cov_read: cover property ($rose(o_mdio_oe));
  cov_bicolour: cover property (o_bicolour_led_select);
  cov_xover: cover property (o_port_crossover_enable == 8'h5a);
endmodule : phy_nway_expansion_and_control_props
bind phy_nway_expansion_and_control phy_nway_expansion_and_control_props
  chk_u (.*);

/* tb/mgmt_station_model.sv */
`timescale 1ns/1ps
module mgmt_station_model (
  input wire logic i_clk, // system clock
  input wire logic i_mdio, // resolved data pin
  output logic o_mdc, // management clock, still between frames
  output logic o_mdio, // data we drive
  output logic o_mdio_oe // high while we drive data
);
  logic smp;
  initial
  begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // 5 clocks low, 6 high; sampled just before the rise
  task automatic bit_cyc(input logic d, input logic en);
    @(negedge i_clk);
    o_mdc = 1'b0;
    o_mdio = d;
    o_mdio_oe = en;
    repeat (5) @(negedge i_clk);
    smp = i_mdio;
    o_mdc = 1'b1;
    repeat (5) @(negedge i_clk);
  endtask : bit_cyc
  task automatic frame(input logic wr, input logic [4:0] phy,
    input logic [4:0] idx, input logic [15:0] wd,
    output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    hdr = {phy_nway_pkg::FRAME_START,
      wr ? phy_nway_pkg::OP_WRITE : phy_nway_pkg::OP_READ, phy, idx};
    repeat (32) bit_cyc(1'b1, 1'b1);
    for (int i = 13; i >= 0; i--)
      bit_cyc(hdr[i], 1'b1);
    bit_cyc(1'b1, wr);
    bit_cyc(1'b0, wr);
    ta = smp;
    for (int i = 15; i >= 0; i--)
    begin
      bit_cyc(wd[i], wr);
      rd[i] = smp;
    end
    @(negedge i_clk);
    o_mdc = 1'b0;
    o_mdio_oe = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask : frame
endmodule : mgmt_station_model

/* tb/tb_phy_nway_expansion_and_control.sv */
`timescale 1ns/1ps
module tb_phy_nway_expansion_and_control;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [1:0] led = 2'b00;
  logic [6:0] strap = 7'h00;
  logic pd = 1'b0, pg = 1'b0, an = 1'b0, pa = 1'b0;
  logic mdc, m_drv, m_en, o_mdio, o_mdio_oe, mdio_w, ta;
  logic [15:0] rd;
  wire [15:0] outs;
  wire [7:0] xov, mdix;
  int err_count = 0;
  int total_checks = 0;
  localparam logic [4:0] phy_addr = 5'h05;
  localparam logic [4:0] ctl = phy_nway_pkg::REG_CONTROL_ONE;
  // pull-up on the data pin when nobody drives it
  assign mdio_w = o_mdio_oe ? o_mdio : (m_en ? m_drv : 1'b1);
  assign outs[5] = |xov;
  always #5 i_clk = ~i_clk;
  mgmt_station_model mgmt_u (.i_clk(i_clk), .i_mdio(mdio_w), .o_mdc(mdc),
    .o_mdio(m_drv), .o_mdio_oe(m_en));
  phy_nway_expansion_and_control dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
    .i_phy_addr_strap(phy_addr), .i_led_style_field(led), .i_strap(strap),
    .i_pd_fault(pd), .i_page_received(pg), .i_an_enable(an),
    .i_partner_an_able(pa), .o_bicolour_led_select(outs[15]),
    .o_fast_slew(outs[14]), .o_remote_fault_consider(outs[13]),
    .o_forced_link_led_suppress(outs[12]),
    .o_ternary_line_speed_detect(outs[11]),
    .o_receive_clock_invert(outs[10]), .o_receive_clock_delay(outs[9]),
    .o_mac_interface_select(outs[8]), .o_auto_power_save_enable(outs[7]),
    .o_negotiation_power_save_off(outs[6]), .o_port_crossover_enable(xov),
    .o_mdix_select(mdix), .o_far_end_fault_off(outs[4]),
    .o_repeater_mode(outs[3]), .o_long_transmit_guard_enable(outs[2]),
    .o_collision_test_check_enable(outs[1]), .o_dsp_watchdog_skip(outs[0]));
  task automatic test_done();
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp16
  task automatic wr_reg(input logic [4:0] idx, input logic [15:0] d);
    mgmt_u.frame(1'b1, phy_addr, idx, d, rd, ta);
  endtask : wr_reg
  task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp,
    input string what);
    mgmt_u.frame(1'b0, phy_addr, idx, 16'h0000, rd, ta);
    cmp16({15'h0000, ta}, 16'h0000, "turnaround");
    cmp16(rd, exp, what);
  endtask : rd_chk
  task automatic chk_outs(input logic [15:0] v);
    cmp16(outs, {v[15] & (led == 2'b11), v[14:0]}, "control outputs");
  endtask : chk_outs
  task automatic do_reset(input logic [1:0] l, input logic [6:0] s);
    @(negedge i_clk);
    i_rstn = 1'b0;
    led = l;
    strap = s;
    repeat (8) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (12) @(negedge i_clk);
  endtask : do_reset
  task automatic t_defaults(input logic [15:0] exp);
    rd_chk(ctl, exp, "control default");
    chk_outs(exp);
    rd_chk(phy_nway_pkg::REG_CROSSOVER, 16'hff00, "xover default");
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0000, "status default");
  endtask : t_defaults
  task automatic t_ctrl_rw();
    logic [15:0] vals [5];
    logic [15:0] e;
    vals = '{16'hffff, 16'h0000, 16'haaaa, 16'h5555, 16'h8421};
    foreach (vals[i])
    begin
      wr_reg(ctl, vals[i]);
      e = vals[i] | 16'h0100;
      rd_chk(ctl, e, "control readback");
      chk_outs(e);
    end
  endtask : t_ctrl_rw
  task automatic t_xover();
    wr_reg(phy_nway_pkg::REG_CROSSOVER, 16'h5a3c);
    rd_chk(phy_nway_pkg::REG_CROSSOVER, 16'h5a3c, "xover rw");
    cmp16({xov, mdix}, 16'h5a3c, "per port xover");
    wr_reg(ctl, 16'h8501);
    cmp16({xov, mdix}, 16'h003c, "global xover off");
  endtask : t_xover
  task automatic t_expansion();
    pd = 1'b1;
    pg = 1'b1;
    @(negedge i_clk);
    pd = 1'b0;
    pg = 1'b0;
    repeat (4) @(negedge i_clk);
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0012, "latched");
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0000, "cleared");
    an = 1'b1;
    pa = 1'b1;
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0001, "partner able");
    pa = 1'b0;
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0000, "partner unable");
    an = 1'b0;
    pa = 1'b1;
    rd_chk(phy_nway_pkg::REG_EXPANSION, 16'h0000, "nway off");
  endtask : t_expansion
  task automatic t_unmapped();
    wr_reg(5'h11, 16'hffff);
    rd_chk(5'h11, 16'h0000, "unmapped read");
    mgmt_u.frame(1'b1, 5'h06, ctl, 16'h0000, rd, ta);
    rd_chk(ctl, 16'h8501, "foreign address write");
  endtask : t_unmapped
  initial
  begin
    do_reset(2'b00, 7'h6c);
    t_defaults(16'h15ac);
    t_ctrl_rw();
    t_xover();
    t_expansion();
    t_unmapped();
    do_reset(2'b11, 7'h13);
    t_defaults(16'h5bac);
    t_ctrl_rw();
    test_done();
  end
  // about 40 frames of some 720 clocks each fit well inside this span
  initial
  begin
    #600000;
    err_count++;
    test_done();
  end
endmodule : tb_phy_nway_expansion_and_control
